//--- common/pwb_pkg.sv
// Constants, register map and encodings for the pin, PWM and button unit
package pwb_pkg;
	localparam int PIN_NUM = 21;
	localparam int PIN_IDX_W = 5;
	localparam int DUTY_W = 10;
	localparam int ADC_W = 10;
	localparam int PERIOD_W = 24;
	localparam int CNT_W = 16;

	// Capability tiers, one bit per pin index; 17 and 18 are absent
	localparam logic [20:0] PIN_PRESENT_MASK = 21'h19FFFF;
	localparam logic [20:0] PIN_ANALOG_MASK = 21'h00041F;
	localparam logic [20:0] PIN_TOUCH_MASK = 21'h000007;
	localparam logic [4:0] KEY_A_PIN = 5'h05;
	localparam logic [4:0] KEY_B_PIN = 5'h0B;

	// Byte offsets on the register bus
	localparam logic [7:0] REG_PIN_SEL = 8'h00;
	localparam logic [7:0] REG_DOUT = 8'h04;
	localparam logic [7:0] REG_DIN = 8'h08;
	localparam logic [7:0] REG_PULL = 8'h0C;
	localparam logic [7:0] REG_MODE = 8'h10;
	localparam logic [7:0] REG_PWM_DUTY = 8'h14;
	localparam logic [7:0] REG_PERIOD_US = 8'h18;
	localparam logic [7:0] REG_PERIOD_MS = 8'h1C;
	localparam logic [7:0] REG_ANALOG = 8'h20;
	localparam logic [7:0] REG_TOUCH = 8'h24;
	localparam logic [7:0] REG_KEY_LEVEL = 8'h28;
	localparam logic [7:0] REG_KEY_A_PRESSED = 8'h2C;
	localparam logic [7:0] REG_KEY_B_PRESSED = 8'h30;
	localparam logic [7:0] REG_KEY_A_COUNT = 8'h34;
	localparam logic [7:0] REG_KEY_B_COUNT = 8'h38;

	typedef enum logic [3:0] {
		PWB_MODE_UNUSED = 4'h0,
		PWB_MODE_ANALOG = 4'h1,
		PWB_MODE_READ_DIGITAL = 4'h2,
		PWB_MODE_WRITE_DIGITAL = 4'h3,
		PWB_MODE_DISPLAY = 4'h4,
		PWB_MODE_BUTTON = 4'h5,
		PWB_MODE_MUSIC = 4'h6,
		PWB_MODE_AUDIO = 4'h7,
		PWB_MODE_TOUCH = 4'h8,
		PWB_MODE_I2C = 4'h9,
		PWB_MODE_SPI = 4'hA
	} pwb_mode_t;

	typedef enum logic [1:0] {
		PWB_PULL_NONE = 2'h0,
		PWB_PULL_DOWN = 2'h1,
		PWB_PULL_UP = 2'h2
	} pwb_pull_t;

	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int US_NS = 1000;
	localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
	localparam int MS_US = 1000;
	localparam int DEBOUNCE_MS = 5;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int PERIOD_MIN_US = 256;
	localparam int PERIOD_MIN_MS = 1;
	localparam int PERIOD_RESET_US = 20000;
	localparam int DUTY_FULL = 1023;
endpackage

//--- rtl/pwb_key_filter.sv
// Synchroniser, debouncer and press edge detector for one push-button
`timescale 1ns/1ps
`default_nettype none
module pwb_key_filter
	import pwb_pkg::*;
#(
	parameter int STABLE_CYCLES = DEBOUNCE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic key_raw_n,
	output logic key_level,
	output logic key_press
);
	initial begin
		if (STABLE_CYCLES < 1) begin
			$error("STABLE_CYCLES must be at least 1");
		end
	end

	localparam int CW = $clog2(STABLE_CYCLES + 1);
	localparam logic [CW-1:0] STABLE_LAST = CW'(STABLE_CYCLES - 1);

	logic sync1_r;
	logic sync2_r;
	logic [CW-1:0] stab_cnt_r;
	logic level_r;
	logic press_r;

	wire differs = (~sync2_r) != level_r;
	wire settle = differs && (stab_cnt_r == STABLE_LAST);

	// Button pulls the pin low; a change must hold for the whole window
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			stab_cnt_r <= '0;
			level_r <= 1'b0;
			press_r <= 1'b0;
		end else begin
			sync1_r <= key_raw_n;
			sync2_r <= sync1_r;
			stab_cnt_r <= (differs && !settle) ? stab_cnt_r + CW'(1) : '0;
			if (settle) begin
				level_r <= ~sync2_r;
			end
			press_r <= settle && sync2_r == 1'b0;
		end
	end

	assign key_level = level_r;
	assign key_press = press_r;
endmodule
`default_nettype wire

//--- rtl/pwb_pin_unit.sv
// Pin unit: digital I/O, pulls, mode tracking, PWM, analog, touch and buttons
`timescale 1ns/1ps
`default_nettype none
module pwb_pin_unit
	import pwb_pkg::*;
#(
	parameter int DEBOUNCE_CLKS = DEBOUNCE_CYCLES,
	parameter int PERIOD_DEF_US = PERIOD_RESET_US
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [PIN_NUM-1:0] pin_in,
	output logic [PIN_NUM-1:0] pin_out,
	output logic [PIN_NUM-1:0] pin_oe_n,
	output logic [PIN_NUM-1:0] pin_pull_up,
	output logic [PIN_NUM-1:0] pin_pull_down,
	input wire logic [PIN_NUM*ADC_W-1:0] adc_sample,
	output logic [1:0] key_held_level
);
	initial begin
		if (DEBOUNCE_CLKS < 1 || PERIOD_DEF_US < PERIOD_MIN_US || PERIOD_DEF_US >= (1 << PERIOD_W)) begin
			$error("pwb_pin_unit parameter out of range");
		end
	end

	localparam logic [PERIOD_W-1:0] PERIOD_DEF = PERIOD_W'(PERIOD_DEF_US);
	localparam logic [PERIOD_W-1:0] PERIOD_MIN = PERIOD_W'(PERIOD_MIN_US);
	localparam logic [31:0] PERIOD_MS_MIN = 32'(PERIOD_MIN_MS);
	localparam logic [31:0] PERIOD_MS_MAX = 32'(((1 << PERIOD_W) - 1) / MS_US);
	localparam logic [9:0] DUTY_MAX = 10'(DUTY_FULL);
	localparam logic [5:0] US_LAST = 6'(US_CYCLES - 1);

	// Bus access decode
	logic ack_r;
	logic [31:0] dat_r;
	wire req = wb_cyc_i && wb_stb_i && !ack_r;
	wire wr = req && wb_we_i;
	wire rd = req && !wb_we_i;
	wire wr_lo = wr && wb_sel_i[0];
	wire wr_full = wr && (wb_sel_i == 4'hF);

	// Pin selection, per-pin state and the shared PWM timebase
	logic [PIN_IDX_W-1:0] sel_r;
	pwb_mode_t mode_r [PIN_NUM];
	pwb_pull_t pull_r [PIN_NUM];
	logic [PIN_NUM-1:0] level_r;
	logic [PIN_NUM-1:0] pwm_en_r;
	logic [DUTY_W-1:0] duty_r [PIN_NUM];
	logic [PERIOD_W-1:0] period_r;
	logic [PERIOD_W-1:0] period_act_r;
	logic [PERIOD_W-1:0] pwm_us_r;
	logic [5:0] us_div_r;
	logic [PIN_NUM-1:0] pwm_level;

	// Selected pin and its capabilities
	wire sel_ok = sel_r < PIN_IDX_W'(PIN_NUM) && PIN_PRESENT_MASK[sel_r];
	wire sel_ana = sel_ok && PIN_ANALOG_MASK[sel_r];
	wire sel_touch = sel_ok && PIN_TOUCH_MASK[sel_r];
	wire [ADC_W-1:0] sel_adc = adc_sample[sel_r*ADC_W +: ADC_W];
	wire pwb_mode_t sel_mode = sel_ok ? mode_r[sel_r] : PWB_MODE_UNUSED;
	wire pwb_pull_t sel_pull = sel_ok ? pull_r[sel_r] : PWB_PULL_NONE;

	wire hit_sel = wb_adr_i == REG_PIN_SEL;
	wire hit_dout = wb_adr_i == REG_DOUT;
	wire hit_din = wb_adr_i == REG_DIN;
	wire hit_pull = wb_adr_i == REG_PULL;
	wire hit_mode = wb_adr_i == REG_MODE;
	wire hit_duty = wb_adr_i == REG_PWM_DUTY;
	wire hit_per_us = wb_adr_i == REG_PERIOD_US;
	wire hit_per_ms = wb_adr_i == REG_PERIOD_MS;
	wire hit_ana = wb_adr_i == REG_ANALOG;
	wire hit_touch = wb_adr_i == REG_TOUCH;
	wire hit_lvl = wb_adr_i == REG_KEY_LEVEL;
	wire hit_pa = wb_adr_i == REG_KEY_A_PRESSED;
	wire hit_pb = wb_adr_i == REG_KEY_B_PRESSED;
	wire hit_ca = wb_adr_i == REG_KEY_A_COUNT;
	wire hit_cb = wb_adr_i == REG_KEY_B_COUNT;

	// Pin actions implied by the access
	wire act_dout = wr_lo && hit_dout && sel_ok;
	wire act_din = rd && hit_din && sel_ok;
	wire act_pull = wr_lo && hit_pull && sel_ok;
	wire act_mode = wr_lo && hit_mode && sel_ok && wb_dat_i[3:0] <= PWB_MODE_SPI;
	wire act_duty = wr && hit_duty && wb_sel_i[1:0] == 2'h3 && sel_ok;
	wire act_ana = rd && hit_ana && sel_ana;
	wire act_touch = rd && hit_touch && sel_touch;
	wire pwb_pull_t pull_req = (wb_dat_i[1:0] == PWB_PULL_UP) ? PWB_PULL_UP :
		(wb_dat_i[1:0] == PWB_PULL_DOWN) ? PWB_PULL_DOWN : PWB_PULL_NONE;

	// Period writes below the minimum are refused so the counter stays sane
	wire [31:0] ms_us = wb_dat_i * 32'(MS_US);
	wire per_us_ok = wr_full && hit_per_us && wb_dat_i < 32'(1 << PERIOD_W) && wb_dat_i[PERIOD_W-1:0] >= PERIOD_MIN;
	wire per_ms_ok = wr_full && hit_per_ms && wb_dat_i >= PERIOD_MS_MIN && wb_dat_i <= PERIOD_MS_MAX;

	// Buttons
	logic [1:0] key_level;
	logic [1:0] key_press;
	logic [1:0] pressed_r;
	logic [CNT_W-1:0] count_r [2];
	logic [1:0] key_lvl_r;
	wire [1:0] rd_pressed = {rd && hit_pb, rd && hit_pa};
	wire [1:0] rd_count = {rd && hit_cb, rd && hit_ca};

	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_key
			pwb_key_filter #(
				.STABLE_CYCLES(DEBOUNCE_CLKS)
			) u_key (
				.ref_clk(ref_clk),
				.rst(rst),
				.key_raw_n(pin_in[k == 0 ? KEY_A_PIN : KEY_B_PIN]),
				.key_level(key_level[k]),
				.key_press(key_press[k])
			);

			always_ff @(posedge ref_clk) begin
				if (rst) begin
					pressed_r[k] <= 1'b0;
					count_r[k] <= '0;
				end else begin
					// A press in the clearing cycle survives
					pressed_r[k] <= key_press[k] | (pressed_r[k] & ~rd_pressed[k]);
					if (rd_count[k]) begin
						count_r[k] <= {{(CNT_W-1){1'b0}}, key_press[k]};
					end else if (key_press[k] && count_r[k] != '1) begin
						count_r[k] <= count_r[k] + CNT_W'(1);
					end
				end
			end
		end
	endgenerate

	// Read data selection
	wire [31:0] rd_data =
		hit_sel ? {27'h0, sel_r} :
		hit_dout ? {31'h0, sel_ok & level_r[sel_r]} :
		hit_din ? {31'h0, sel_ok & pin_in[sel_r]} :
		hit_pull ? {30'h0, sel_pull} :
		hit_mode ? {28'h0, sel_mode} :
		hit_duty ? {22'h0, sel_ok ? duty_r[sel_r] : 10'h0} :
		hit_per_us ? {8'h0, period_r} :
		hit_per_ms ? {8'h0, period_r / PERIOD_W'(MS_US)} :
		hit_ana ? {22'h0, sel_ana ? sel_adc : 10'h0} :
		hit_touch ? {31'h0, sel_touch & ~pin_in[sel_r]} :
		hit_lvl ? {30'h0, key_level} :
		hit_pa ? {31'h0, pressed_r[0]} :
		hit_pb ? {31'h0, pressed_r[1]} :
		hit_ca ? {16'h0, count_r[0]} :
		hit_cb ? {16'h0, count_r[1]} :
		32'h0;

	// Every access is answered one cycle later, unmapped ones with zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
			sel_r <= '0;
		end else begin
			ack_r <= req;
			if (rd) begin
				dat_r <= rd_data;
			end
			if (wr_lo && hit_sel) begin
				sel_r <= wb_dat_i[PIN_IDX_W-1:0];
			end
		end
	end

	// Mode and pull tracking; only the selected pin is updated
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < PIN_NUM; i++) begin
				mode_r[i] <= PWB_MODE_UNUSED;
				pull_r[i] <= PWB_PULL_NONE;
				duty_r[i] <= '0;
			end
			level_r <= '0;
			pwm_en_r <= '0;
		end else begin
			for (int i = 0; i < PIN_NUM; i++) begin
				if (sel_r == PIN_IDX_W'(i)) begin
					if (act_dout) begin
						mode_r[i] <= PWB_MODE_WRITE_DIGITAL;
						level_r[i] <= wb_dat_i[0];
						pwm_en_r[i] <= 1'b0;
					end else if (act_din) begin
						mode_r[i] <= PWB_MODE_READ_DIGITAL;
						pull_r[i] <= PWB_PULL_DOWN;
						pwm_en_r[i] <= 1'b0;
					end else if (act_pull) begin
						mode_r[i] <= PWB_MODE_READ_DIGITAL;
						pull_r[i] <= pull_req;
						pwm_en_r[i] <= 1'b0;
					end else if (act_duty) begin
						mode_r[i] <= PWB_MODE_ANALOG;
						duty_r[i] <= (wb_dat_i[9:0] > DUTY_MAX) ? DUTY_MAX : wb_dat_i[9:0];
						pwm_en_r[i] <= 1'b1;
					end else if (act_ana) begin
						mode_r[i] <= PWB_MODE_ANALOG;
						pull_r[i] <= PWB_PULL_NONE;
						pwm_en_r[i] <= 1'b0;
					end else if (act_touch) begin
						mode_r[i] <= PWB_MODE_TOUCH;
						pull_r[i] <= PWB_PULL_UP;
						pwm_en_r[i] <= 1'b0;
					end else if (act_mode) begin
						mode_r[i] <= pwb_mode_t'(wb_dat_i[3:0]);
						pwm_en_r[i] <= 1'b0;
					end
				end
			end
		end
	end

	// PWM timebase: one-microsecond enable, period latched only at wrap
	wire us_tick = us_div_r == US_LAST;
	wire pwm_wrap = us_tick && (pwm_us_r >= period_act_r - PERIOD_W'(1));

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			us_div_r <= '0;
			pwm_us_r <= '0;
			period_r <= PERIOD_DEF;
			period_act_r <= PERIOD_DEF;
		end else begin
			us_div_r <= us_tick ? 6'h00 : us_div_r + 6'h01;
			if (per_us_ok) begin
				period_r <= wb_dat_i[PERIOD_W-1:0];
			end else if (per_ms_ok) begin
				period_r <= ms_us[PERIOD_W-1:0];
			end
			if (pwm_wrap) begin
				pwm_us_r <= '0;
				period_act_r <= period_r;
			end else if (us_tick) begin
				pwm_us_r <= pwm_us_r + PERIOD_W'(1);
			end
		end
	end

	// High while count*1023 < duty*period: 0 never high, 1023 always high
	wire [PERIOD_W+DUTY_W-1:0] pos_scaled = pwm_us_r * (PERIOD_W+DUTY_W)'(DUTY_FULL);
	genvar p;
	generate
		for (p = 0; p < PIN_NUM; p++) begin : g_pwm
			wire [PERIOD_W+DUTY_W-1:0] thr = duty_r[p] * period_act_r;
			assign pwm_level[p] = pos_scaled < thr;
		end
	endgenerate

	// Registered pin drivers; absent indices never drive
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_out <= '0;
			pin_oe_n <= '1;
			pin_pull_up <= '0;
			pin_pull_down <= '0;
			key_lvl_r <= '0;
		end else begin
			for (int i = 0; i < PIN_NUM; i++) begin
				pin_out[i] <= PIN_PRESENT_MASK[i] & (pwm_en_r[i] ? pwm_level[i] : level_r[i]);
				pin_oe_n[i] <= ~(PIN_PRESENT_MASK[i] & (pwm_en_r[i] | mode_r[i] == PWB_MODE_WRITE_DIGITAL));
				pin_pull_up[i] <= PIN_PRESENT_MASK[i] & (pull_r[i] == PWB_PULL_UP);
				pin_pull_down[i] <= PIN_PRESENT_MASK[i] & (pull_r[i] == PWB_PULL_DOWN);
			end
			key_lvl_r <= key_level;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign key_held_level = key_lvl_r;
endmodule
`default_nettype wire

//--- tb/pwb_board_model.sv
// Board model: keys, touch pads, pulls and external drivers on the pins
`timescale 1ns/1ps
`default_nettype none
module pwb_board_model
	import pwb_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [PIN_NUM-1:0] pin_out,
	input wire logic [PIN_NUM-1:0] pin_oe_n,
	input wire logic [PIN_NUM-1:0] pin_pull_up,
	input wire logic [PIN_NUM-1:0] pin_pull_down,
	input wire logic [1:0] key_down,
	input wire logic [2:0] pad_touch,
	input wire logic [PIN_NUM-1:0] ext_en,
	input wire logic [PIN_NUM-1:0] ext_val,
	output logic [PIN_NUM-1:0] pin_in,
	output logic [PIN_NUM*ADC_W-1:0] adc_sample
);
	logic [PIN_NUM-1:0] last_r = '0;
	always_ff @(posedge ref_clk) last_r <= pin_in;
	// A floating pin flips every cycle so no stale level reads as valid
	always_comb begin
		for (int i = 0; i < PIN_NUM; i++) begin
			adc_sample[i*ADC_W+:ADC_W] = ADC_W'(i * 97 + 3);
			if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
			else if (ext_en[i]) pin_in[i] = ext_val[i];
			else if (i == 5 || i == 11) pin_in[i] = !key_down[i == 11];
			else if (i < 3) pin_in[i] = !pad_touch[i % 3];
			else if (pin_pull_up[i] || pin_pull_down[i]) pin_in[i] = pin_pull_up[i];
			else pin_in[i] = !last_r[i];
		end
	end
endmodule
`default_nettype wire

//--- tb/pwb_pin_unit_props.sv
// Bus and pin checks for the pin unit
`timescale 1ns/1ps
`default_nettype none
module pwb_pin_unit_props
	import pwb_pkg::*;
#(
	parameter int DEBOUNCE_CLKS = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [PIN_NUM-1:0] pin_in,
	input wire logic [PIN_NUM-1:0] pin_oe_n,
	input wire logic [PIN_NUM-1:0] pin_pull_up,
	input wire logic [PIN_NUM-1:0] pin_pull_down,
	input wire logic [1:0] key_held_level
);
	logic [7:0] lo_a_r;
	logic [7:0] lo_b_r;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Low time of each key pin, capped so it never wraps
	always_ff @(posedge ref_clk) begin
		lo_a_r <= (rst || pin_in[KEY_A_PIN]) ? 8'h00 : lo_a_r + {7'h00, lo_a_r != 8'hFF};
		lo_b_r <= (rst || pin_in[KEY_B_PIN]) ? 8'h00 : lo_b_r + {7'h00, lo_b_r != 8'hFF};
	end
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack after request");
	property p_ack_one;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_hold;
		$changed(wb_dat_o) |-> wb_ack_o;
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
	property p_absent;
		pin_oe_n[18:17] == 2'h3 && (pin_pull_up[18:17] | pin_pull_down[18:17]) == 2'h0;
	endproperty
	a_absent: assert property (p_absent) else $error("absent pin became active");
	property p_pull_excl;
		(pin_pull_up & pin_pull_down) == '0;
	endproperty
	a_pull_excl: assert property (p_pull_excl) else $error("both pulls on one pin");
	property p_key_a;
		$rose(key_held_level[0]) |-> lo_a_r >= DEBOUNCE_CLKS;
	endproperty
	a_key_a: assert property (p_key_a) else $error("key A held before debounce");
	property p_key_b;
		$rose(key_held_level[1]) |-> lo_b_r >= DEBOUNCE_CLKS;
	endproperty
	a_key_b: assert property (p_key_b) else $error("key B held before debounce");
endmodule
bind pwb_pin_unit pwb_pin_unit_props #(.DEBOUNCE_CLKS(DEBOUNCE_CLKS)) props_u (.ref_clk(ref_clk), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in(pin_in),
	.pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
	.key_held_level(key_held_level));
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the pin unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pwb_pkg::*;
;
	localparam int DEB = 8;
	localparam int PER = 256;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] dout;
	logic [31:0] rd;
	logic ack;
	logic [PIN_NUM-1:0] pin_in, pin_out, oe_n, pu, pd;
	logic [PIN_NUM-1:0] ext_en = '0;
	logic [PIN_NUM-1:0] ext_val = '0;
	logic [PIN_NUM*ADC_W-1:0] adc;
	logic [1:0] key;
	logic [1:0] key_down = 2'h0;
	logic [2:0] pad = 3'h0;
	int n_mismatch = 0;
	int check_count = 0;
	int hi;
	int duty[3] = '{32'h0, 32'h3FF, 32'h1FF};
	always #10 ref_clk = ~ref_clk;
	pwb_pin_unit #(.DEBOUNCE_CLKS(DEB), .PERIOD_DEF_US(PER)) dut_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout),
		.wb_ack_o(ack), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_pull_up(pu),
		.pin_pull_down(pd), .adc_sample(adc), .key_held_level(key));
	pwb_board_model board_u (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_pull_up(pu),
		.pin_pull_down(pd), .key_down(key_down), .pad_touch(pad), .ext_en(ext_en), .ext_val(ext_val),
		.pin_in(pin_in), .adc_sample(adc));
	task automatic stop_test();
		$display("Mismatches %0d, checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic cycle: held until ack is sampled, released at that edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge ref_clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		do begin
			@(posedge ref_clk);
			t++;
		end while (ack !== 1'h1 && t < 64);
		if (t >= 64) chk(32'h0, 32'h1);
		rd = dout;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic hold(input int k, input int n);
		@(posedge ref_clk);
		key_down[k] <= 1'h1;
		repeat (n) @(posedge ref_clk);
		key_down[k] <= 1'h0;
		repeat (30) @(posedge ref_clk);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'h0;
		rd_chk(REG_PERIOD_US, PER);
		for (int i = 0; i < PIN_NUM; i++) begin
			bus(1'h1, REG_PIN_SEL, i);
			bus(1'h1, REG_DOUT, 32'h1);
			repeat (2) @(negedge ref_clk);
			chk(oe_n[i], !PIN_PRESENT_MASK[i]);
			chk(pin_out[i], PIN_PRESENT_MASK[i]);
			rd_chk(REG_MODE, PIN_PRESENT_MASK[i] ? 32'h3 : 32'h0);
		end
		bus(1'h1, REG_DOUT, 32'h0);
		repeat (2) @(negedge ref_clk);
		chk(pin_out[20], 32'h0);
		bus(1'h1, REG_PIN_SEL, 32'h8);
		bus(1'h0, REG_DIN, 32'h0);
		for (int v = 0; v < 2; v++) begin
			ext_en[8] <= 1'h1;
			ext_val[8] <= v[0];
			repeat (4) @(posedge ref_clk);
			rd_chk(REG_DIN, v);
		end
		rd_chk(REG_PULL, PWB_PULL_DOWN);
		chk(pd[8], 32'h1);
		rd_chk(REG_ANALOG, 32'h0);
		bus(1'h1, REG_PIN_SEL, 32'hC);
		bus(1'h1, REG_MODE, PWB_MODE_DISPLAY);
		bus(1'h1, REG_PULL, PWB_PULL_UP);
		rd_chk(REG_PULL, PWB_PULL_UP);
		rd_chk(REG_MODE, PWB_MODE_READ_DIGITAL);
		chk(pu[12], 32'h1);
		for (int m = 0; m < 12; m++) begin
			bus(1'h1, REG_MODE, m);
			rd_chk(REG_MODE, m > 10 ? 32'hA : m);
		end
		bus(1'h1, REG_PIN_SEL, 32'h3);
		rd_chk(REG_ANALOG, 32'h126);
		rd_chk(REG_PULL, PWB_PULL_NONE);
		rd_chk(REG_TOUCH, 32'h0);
		bus(1'h1, REG_PIN_SEL, 32'h1);
		bus(1'h0, REG_TOUCH, 32'h0);
		for (int v = 1; v >= 0; v--) begin
			pad[1] <= v[0];
			repeat (4) @(posedge ref_clk);
			rd_chk(REG_TOUCH, v);
		end
		rd_chk(REG_PULL, PWB_PULL_UP);
		rd_chk(REG_MODE, PWB_MODE_TOUCH);
		bus(1'h1, REG_PIN_SEL, 32'h4);
		foreach (duty[k]) begin
			bus(1'h1, REG_PWM_DUTY, duty[k]);
			repeat (3) @(negedge ref_clk);
			hi = 0;
			repeat (PER * US_CYCLES) begin
				@(negedge ref_clk);
				if (pin_out[4] === 1'h1) hi++;
			end
			chk(hi, (duty[k] * PER + 1022) / 1023 * US_CYCLES);
		end
		bus(1'h1, REG_PERIOD_US, 32'h101);
		bus(1'h1, REG_PERIOD_US, 32'hFF);
		rd_chk(REG_PERIOD_US, 32'h101);
		bus(1'h1, REG_PERIOD_MS, 32'h1);
		bus(1'h1, REG_PERIOD_MS, 32'h0);
		rd_chk(REG_PERIOD_US, 32'h3E8);
		rd_chk(REG_PERIOD_MS, 32'h1);
		for (int i = 5; i < 12; i += 6) begin
			bus(1'h1, REG_PIN_SEL, i);
			bus(1'h0, REG_DIN, 32'h0);
		end
		hold(0, 3);
		rd_chk(REG_KEY_A_PRESSED, 32'h0);
		@(posedge ref_clk);
		key_down[0] <= 1'h1;
		repeat (30) @(posedge ref_clk);
		rd_chk(REG_KEY_LEVEL, 32'h1);
		chk(key, 32'h1);
		@(posedge ref_clk);
		key_down[0] <= 1'h0;
		repeat (30) @(posedge ref_clk);
		rd_chk(REG_KEY_LEVEL, 32'h0);
		chk(key, 32'h0);
		hold(0, 30);
		hold(0, 30);
		rd_chk(REG_KEY_A_PRESSED, 32'h1);
		rd_chk(REG_KEY_A_PRESSED, 32'h0);
		rd_chk(REG_KEY_A_COUNT, 32'h3);
		rd_chk(REG_KEY_A_COUNT, 32'h0);
		hold(1, 30);
		rd_chk(REG_KEY_B_COUNT, 32'h1);
		rd_chk(REG_KEY_B_PRESSED, 32'h1);
		// Mid-run reset must bring back the power-up state
		rst <= 1'h1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		rd_chk(REG_PERIOD_US, PER);
		bus(1'h1, REG_PIN_SEL, 32'hC);
		rd_chk(REG_MODE, 32'h0);
		rd_chk(REG_PULL, 32'h0);
		chk(pu[12], 32'h0);
		bus(1'h1, 8'h3C, 32'hFFFFFFFF);
		rd_chk(8'h3C, 32'h0);
		stop_test();
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		n_mismatch++;
		stop_test();
	end
endmodule
`default_nettype wire
